// File: core/tmr_cfg.svh
// Register offsets, field positions, reset values and prescaler taps
// Assumes inclusion by the timer modules and package users
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ==========================================================
// Register map, byte addresses on APB
`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_CNT  8'h04
`define TMR_OFF_CMP  8'h08
`define TMR_OFF_MASK 8'h0C
`define TMR_OFF_FLAG 8'h10
`define TMR_OFF_STAT 8'h14

// ==========================================================
// Fields and reset values
`define TMR_CTRL_RST 8'h00
`define TMR_CNT_RST  8'h00
`define TMR_CMP_RST  8'h00
`define TMR_FOC_BIT  7
`define TMR_FLG_OVF  0
`define TMR_FLG_CMP  1
`define TMR_BOTTOM   8'h00
`define TMR_MAX      8'hFF

// ==========================================================
// Prescaler width and divide taps in bits
`define TMR_PRE_W    10
`define TMR_TAP_8    3
`define TMR_TAP_64   6
`define TMR_TAP_256  8
`define TMR_TAP_1024 10

`endif

// File: core/tmr_pkg.sv
// Types shared by the timer modules
// Assumes the cfg header for numeric constants
package tmr_pkg;
   typedef enum logic [1:0] {
      TMR_NORMAL, TMR_PC_PWM, TMR_CTC, TMR_FAST_PWM
   } tmr_mode_t;

   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64,
      CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
   } tmr_clksel_t;

   typedef struct packed {
      logic        foc;
      logic [1:0]  com;
      tmr_mode_t   mode;
      tmr_clksel_t cs;
   } tmr_ctrl_t;

   typedef struct packed {
      logic cmp;
      logic ovf;
   } tmr_irq_t;
endpackage : tmr_pkg

// File: core/tmr_clksel.sv
// Timer clock selection: prescaler taps or external count input edge
// Assumes ext_count_input is asynchronous to pclk
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"

module tmr_clksel
   import tmr_pkg::*;
   #(parameter int PRE_W = `TMR_PRE_W)
   (
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  tmr_clksel_t cs,
   input  wire  logic        ext_count_input,
   output logic              tick
   );

   logic [PRE_W-1:0] pre_r;
   logic             sync1_r;
   logic             sync2_r;
   logic             last_r;

   // ==========================================================
   // Free running prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // ==========================================================
   // Two stage synchroniser, then edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         last_r  <= 1'b0;
      end else begin
         sync1_r <= ext_count_input;
         sync2_r <= sync1_r;
         last_r  <= sync2_r;
      end
   end

   always_comb begin
      unique case (cs)
         CS_STOP:     tick = 1'b0;
         CS_DIV1:     tick = 1'b1;
         CS_DIV8:     tick = &pre_r[`TMR_TAP_8-1:0];
         CS_DIV64:    tick = &pre_r[`TMR_TAP_64-1:0];
         CS_DIV256:   tick = &pre_r[`TMR_TAP_256-1:0];
         CS_DIV1024:  tick = &pre_r[`TMR_TAP_1024-1:0];
         CS_EXT_FALL: tick = last_r & ~sync2_r;
         CS_EXT_RISE: tick = sync2_r & ~last_r;
      endcase
   end

   // ==========================================================
   // Checks
   a_stop_no_tick: assert property (
      @(posedge pclk) disable iff (!presetn)
      cs == CS_STOP |-> !tick)
      else $error("tick while clock stopped");

   a_ext_edge_once: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_EXT_RISE && $stable(cs) && tick) |=> !tick)
      else $error("one external edge counted twice");
endmodule : tmr_clksel
`default_nettype wire

// File: core/tmr_wavegen.sv
// Waveform generator driving the compare output register
// Assumes hit and wrap are one-cycle timer events from the counter
`timescale 1ns/1ns
`default_nettype none

module tmr_wavegen
   import tmr_pkg::*;
   (
   input  wire  logic       pclk,
   input  wire  logic       presetn,
   input  wire  tmr_mode_t  mode,
   input  wire  logic [1:0] com,
   input  wire  logic       hit,
   input  wire  logic       wrap,
   input  wire  logic       dir_down,
   input  wire  logic       foc,
   output logic             compare_output
   );

   logic pwm;
   logic nonpwm_val;

   assign pwm = (mode == TMR_PC_PWM) || (mode == TMR_FAST_PWM);

   always_comb begin
      unique case (com)
         2'b00:   nonpwm_val = compare_output;
         2'b01:   nonpwm_val = ~compare_output;
         2'b10:   nonpwm_val = 1'b0;
         2'b11:   nonpwm_val = 1'b1;
      endcase
   end

   // ==========================================================
   // Output register update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_output <= 1'b0;
      end else if (foc && !pwm) begin
         compare_output <= nonpwm_val;
      end else if (hit) begin
         if (!pwm) begin
            compare_output <= nonpwm_val;
         end else if (com[1] && mode == TMR_FAST_PWM) begin
            compare_output <= com[0];
         end else if (com[1]) begin
            compare_output <= com[0] ^ dir_down;
         end
      end else if (wrap && com[1]) begin
         compare_output <= ~com[0];
      end
   end

   a_wave_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode == TMR_CTC && com == 2'b10 && hit && !foc) |=> !compare_output)
      else $error("compare output not cleared on match");
endmodule : tmr_wavegen
`default_nettype wire

// File: core/tmr_top.sv
// 8-bit timer/counter with one compare channel on an APB slave
// Assumes an APB master on pclk; request lines go to an interrupt unit
//
// Overview of operation
// - Counter and compare registers are eight bits
// - Every request visible in the flag register
// - Each request has its own mask bit
// - Clock from prescaler or external count input
// - Clock select picks source and active edge
// - No source selected: counter holds its value
// - Compare value checked against counter every cycle
// - Match drives PWM or frequency output
// - Match sets compare flag, may request interrupt
// - Bottom signalled when counter is zero
// - Max value 0xFF is detected
// - Top is 0xFF or compare value by mode
// - Clear-on-match mode reloads counter to zero
// - Glitch-free phase-correct PWM mode provided
// - Two sources: overflow and compare match
// - Select zero stops timer; counter stays accessible
// - Counter write beats count and clear
// - Flag set at the matching tick, seen next pclk; ack or one clears
// - Counter write blocks match at next tick
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"

module tmr_top
   import tmr_pkg::*;
   #(parameter int PRE_W = `TMR_PRE_W)
   (
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire  logic        ext_count_input,
   input  wire  logic        ovf_irq_ack,
   input  wire  logic        cmp_irq_ack,
   output logic              compare_output,
   output logic              compare_output_en,
   output logic              irq_ovf,
   output logic              irq_cmp
   );

   tmr_ctrl_t   ctrl_r;
   logic [7:0]  count_value_reg_r;
   logic [7:0]  cmp_buf_r;
   logic [7:0]  compare_value_reg_r;
   tmr_irq_t    timer_irq_mask_reg_r;
   tmr_irq_t    timer_irq_flag_reg_r;
   logic        dir_down_r;
   logic        block_r;
   logic [31:0] prdata_r;

   logic        wr;
   logic        setup_rd;
   logic        mapped;
   logic        wr_ctrl;
   logic        wr_cnt;
   logic        wr_cmp;
   logic        wr_mask;
   logic        wr_flag;
   logic        timer_clock;
   logic        pwm;
   logic        eq;
   logic        hit;
   logic        at_bottom;
   logic        at_max;
   logic        at_top;
   logic [7:0]  top_val;
   logic        going_down;
   logic        ovf_ev;
   logic        wrap;
   logic        foc_r;
   logic [7:0]  status;

   // ==========================================================
   // APB decode
   assign wr       = psel & penable & pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign mapped   = paddr == `TMR_OFF_CTRL || paddr == `TMR_OFF_CNT
                  || paddr == `TMR_OFF_CMP || paddr == `TMR_OFF_MASK
                  || paddr == `TMR_OFF_FLAG || paddr == `TMR_OFF_STAT;
   assign wr_ctrl  = wr && paddr == `TMR_OFF_CTRL;
   assign wr_cnt   = wr && paddr == `TMR_OFF_CNT;
   assign wr_cmp   = wr && paddr == `TMR_OFF_CMP;
   assign wr_mask  = wr && paddr == `TMR_OFF_MASK;
   assign wr_flag  = wr && paddr == `TMR_OFF_FLAG;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign prdata   = prdata_r;

   // ==========================================================
   // Timer clock source
   tmr_clksel #(.PRE_W(PRE_W)) u_clksel (
      .pclk            (pclk),
      .presetn         (presetn),
      .cs              (ctrl_r.cs),
      .ext_count_input (ext_count_input),
      .tick            (timer_clock)
   );

   // ==========================================================
   // Conditions of the count sequence
   assign pwm       = ctrl_r.mode == TMR_PC_PWM
                   || ctrl_r.mode == TMR_FAST_PWM;
   assign eq        = count_value_reg_r == compare_value_reg_r;
   assign hit       = timer_clock & eq & ~block_r;
   assign at_bottom = count_value_reg_r == `TMR_BOTTOM;
   assign at_max    = count_value_reg_r == `TMR_MAX;
   assign top_val   = (ctrl_r.mode == TMR_CTC) ? compare_value_reg_r
                                               : `TMR_MAX;
   assign at_top    = count_value_reg_r == top_val;
   assign going_down = at_max | (dir_down_r & ~at_bottom);
   assign ovf_ev    = timer_clock & ~wr_cnt
                    & ((ctrl_r.mode == TMR_PC_PWM) ? (at_bottom & dir_down_r)
                                                   : at_max);
   assign wrap      = timer_clock & ~wr_cnt
                    & ctrl_r.mode == TMR_FAST_PWM & at_max;
   assign status    = {3'h0, compare_output, dir_down_r,
                       at_top, at_max, at_bottom};

   // ==========================================================
   // Control register; force bit is a strobe, never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tmr_ctrl_t'(`TMR_CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_r     <= tmr_ctrl_t'(pwdata[7:0]);
         ctrl_r.foc <= 1'b0;
      end
   end

   // Force strobe acts once the new action and mode bits are in place
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         foc_r <= 1'b0;
      end else begin
         foc_r <= wr_ctrl & pwdata[`TMR_FOC_BIT];
      end
   end

   // ==========================================================
   // Counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value_reg_r <= `TMR_CNT_RST;
      end else if (wr_cnt) begin
         count_value_reg_r <= pwdata[7:0];
      end else if (timer_clock) begin
         unique case (ctrl_r.mode)
            TMR_NORMAL, TMR_FAST_PWM: begin
               count_value_reg_r <= count_value_reg_r + 8'h01;
            end
            TMR_CTC: begin
               if (at_top) begin
                  count_value_reg_r <= `TMR_BOTTOM;
               end else begin
                  count_value_reg_r <= count_value_reg_r + 8'h01;
               end
            end
            TMR_PC_PWM: begin
               if (going_down) begin
                  count_value_reg_r <= count_value_reg_r - 8'h01;
               end else begin
                  count_value_reg_r <= count_value_reg_r + 8'h01;
               end
            end
         endcase
      end
   end

   // Direction only turns in phase-correct mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_down_r <= 1'b0;
      end else if (ctrl_r.mode != TMR_PC_PWM) begin
         dir_down_r <= 1'b0;
      end else if (timer_clock && !wr_cnt) begin
         dir_down_r <= going_down;
      end
   end

   // Match blocking after a counter write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_r <= 1'b0;
      end else if (wr_cnt) begin
         block_r <= 1'b1;
      end else if (timer_clock) begin
         block_r <= 1'b0;
      end
   end

   // ==========================================================
   // Compare value, buffered at MAX in PWM modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_buf_r           <= `TMR_CMP_RST;
         compare_value_reg_r <= `TMR_CMP_RST;
      end else begin
         if (wr_cmp) begin
            cmp_buf_r <= pwdata[7:0];
         end
         if (wr_cmp && !pwm) begin
            compare_value_reg_r <= pwdata[7:0];
         end else if (pwm && timer_clock && at_max) begin
            compare_value_reg_r <= cmp_buf_r;
         end
      end
   end

   // ==========================================================
   // Mask and flags; a set beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq_mask_reg_r <= '0;
      end else if (wr_mask) begin
         timer_irq_mask_reg_r <= tmr_irq_t'(pwdata[1:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq_flag_reg_r <= '0;
      end else begin
         timer_irq_flag_reg_r.cmp <= hit
            | (timer_irq_flag_reg_r.cmp & ~cmp_irq_ack
               & ~(wr_flag & pwdata[`TMR_FLG_CMP]));
         timer_irq_flag_reg_r.ovf <= ovf_ev
            | (timer_irq_flag_reg_r.ovf & ~ovf_irq_ack
               & ~(wr_flag & pwdata[`TMR_FLG_OVF]));
      end
   end

   assign irq_cmp = timer_irq_flag_reg_r.cmp & timer_irq_mask_reg_r.cmp;
   assign irq_ovf = timer_irq_flag_reg_r.ovf & timer_irq_mask_reg_r.ovf;

   // ==========================================================
   // Read data, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_rd) begin
         unique case (paddr)
            `TMR_OFF_CTRL: prdata_r <= {24'h000000, ctrl_r};
            `TMR_OFF_CNT:  prdata_r <= {24'h000000, count_value_reg_r};
            `TMR_OFF_CMP:  prdata_r <= {24'h000000, cmp_buf_r};
            `TMR_OFF_MASK: prdata_r <= {30'h0, timer_irq_mask_reg_r};
            `TMR_OFF_FLAG: prdata_r <= {30'h0, timer_irq_flag_reg_r};
            `TMR_OFF_STAT: prdata_r <= {24'h000000, status};
            default:       prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Waveform generator
   tmr_wavegen u_wavegen (
      .pclk           (pclk),
      .presetn        (presetn),
      .mode           (ctrl_r.mode),
      .com            (ctrl_r.com),
      .hit            (hit),
      .wrap           (wrap),
      .dir_down       (dir_down_r),
      .foc            (foc_r),
      .compare_output (compare_output)
   );

   assign compare_output_en = ctrl_r.com != 2'b00;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_stop_holds: assert property (
      (ctrl_r.cs == CS_STOP && !wr_cnt) |=>
         count_value_reg_r == $past(count_value_reg_r))
      else $error("counter moved while stopped");

   a_write_wins: assert property (
      wr_cnt |=> count_value_reg_r == $past(pwdata[7:0]))
      else $error("counter write lost");

   a_match_blocked: assert property (
      wr_cnt |=> ##1 (!timer_irq_flag_reg_r.cmp
         || $past(timer_irq_flag_reg_r.cmp)))
      else $error("match not blocked after counter write");

   a_cmp_flag_set: assert property (
      hit |=> timer_irq_flag_reg_r.cmp)
      else $error("compare flag not set after match");

   a_cmp_flag_ack: assert property (
      (cmp_irq_ack && !hit) |=> !timer_irq_flag_reg_r.cmp)
      else $error("compare flag not cleared by ack");

   a_ovf_flag_set: assert property (
      ovf_ev |=> timer_irq_flag_reg_r.ovf ##0 count_value_reg_r
         == ((ctrl_r.mode == TMR_PC_PWM) ? 8'h01 : 8'h00))
      else $error("overflow flag or wrap value wrong");

   a_ctc_reload: assert property (
      (ctrl_r.mode == TMR_CTC && timer_clock && at_top && !wr_cnt)
         |=> count_value_reg_r == `TMR_BOTTOM)
      else $error("no reload on match");

   a_pc_turn: assert property (
      (ctrl_r.mode == TMR_PC_PWM && timer_clock && at_max && !wr_cnt)
         |=> dir_down_r && count_value_reg_r == 8'hFE)
      else $error("phase correct count did not turn at max");

   a_pwm_buffered: assert property (
      (pwm && !(timer_clock && at_max)) |=>
         compare_value_reg_r == $past(compare_value_reg_r))
      else $error("compare value changed outside max");

   a_irq_gated: assert property (
      (!timer_irq_mask_reg_r.cmp && !wr_mask) |=> !irq_cmp)
      else $error("masked compare request raised");
endmodule : tmr_top
`default_nettype wire

// File: testbench/timer8_single_compare_pwm_bench.sv
// Self-checking bench for the 8-bit timer with one compare channel
// Assumes tmr_top on APB at 10 MHz, single clock, no partner model
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"

module timer8_single_compare_pwm_bench
   import tmr_pkg::*;
   ;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_count_input;
   logic        ovf_irq_ack;
   logic        cmp_irq_ack;
   logic        compare_output;
   logic        compare_output_en;
   logic        irq_ovf;
   logic        irq_cmp;
   int          bad_count;
   int          tests_run;

   tmr_top u_tmr_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .ext_count_input(ext_count_input), .ovf_irq_ack(ovf_irq_ack),
      .cmp_irq_ack(cmp_irq_ack), .compare_output(compare_output),
      .compare_output_en(compare_output_en), .irq_ovf(irq_ovf),
      .irq_cmp(irq_cmp)
   );

   // ==========================================================
   // Clock, verdict and checking helpers
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic give_verdict;
      $display("checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] ctl(input logic foc, input logic [1:0] com,
                                       input tmr_mode_t m,
                                       input tmr_clksel_t cs);
      return {24'h0, foc, com, m, cs};
   endfunction : ctl

   // Pin level after a forced match for each output action
   function automatic logic force_exp(input logic [1:0] com,
                                      input logic prev);
      case (com)
         2'd1: return ~prev;
         2'd2: return 1'b0;
         2'd3: return 1'b1;
         default: return prev;
      endcase
   endfunction : force_exp

   // One when a seen count lies between lo and four above lo
   function automatic logic [31:0] in_range(input logic [31:0] seen,
                                            input int lo);
      return {31'h0, (seen >= lo) && (seen <= lo + 4)};
   endfunction : in_range

   // ==========================================================
   // APB master
   task automatic apb_xfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q,
                           output logic e);
      int w;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      q = prdata;
      e = pslverr;
      if (w >= 50) begin
         bad_count++;
         $display("ERROR pready expected 1 seen %b", pready);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb_xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb_xfer(1'b0, a, 32'h0, q, e);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // ==========================================================
   // Watchdog
   initial begin
      #(40000 * 100);
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   localparam logic [7:0] OFFS [6] = '{`TMR_OFF_CTRL, `TMR_OFF_CNT,
      `TMR_OFF_CMP, `TMR_OFF_MASK, `TMR_OFF_FLAG, `TMR_OFF_STAT};
   localparam int TAPS [5] = '{0, `TMR_TAP_8, `TMR_TAP_64, `TMR_TAP_256,
                               `TMR_TAP_1024};

   initial begin
      logic [31:0] q;
      logic        e;
      logic        prev;
      logic [7:0]  v;
      logic [1:0]  com;
      int          n;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_count_input = 1'b0;
      ovf_irq_ack = 1'b0;
      cmp_irq_ack = 1'b0;
      presetn = 1'b0;
      bad_count = 0;
      tests_run = 0;
      void'($urandom(53631));
      cyc(8);
      presetn <= 1'b1;
      // Reset values and refused address
      foreach (OFFS[i]) begin
         apb_xfer(1'b0, OFFS[i], 32'h0, q, e);
         chk("reset read", q,
             (OFFS[i] == `TMR_OFF_STAT) ? 32'h1 : 32'h0);
      end
      apb_xfer(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
      chk("unmapped write err", {31'h0, e}, 32'h1);
      apb_xfer(1'b0, 8'h40, 32'h0, q, e);
      chk("unmapped read", q, 32'h0);
      // Forced matches through the toggle, clear and set output actions
      prev = 1'b0;
      for (int i = 0; i < 6; i++) begin
         com = (i < 3) ? 2'(i + 1) : 2'($urandom_range(1, 3));
         wr(`TMR_OFF_CTRL, ctl(1'b1, com, TMR_NORMAL, CS_STOP));
         cyc(2);
         prev = force_exp(com, prev);
         chk("forced output", {31'h0, compare_output}, {31'h0, prev});
         chk("output enable", {31'h0, compare_output_en}, 32'h1);
      end
      wr(`TMR_OFF_CTRL, ctl(1'b1, 2'd2, TMR_PC_PWM, CS_STOP));
      cyc(2);
      chk("force in pwm", {31'h0, compare_output}, {31'h0, prev});
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
      cyc(1);
      chk("output enable off", {31'h0, compare_output_en}, 32'h0);
      // Stopped counter holds a written value
      v = 8'($urandom_range(0, 255));
      wr(`TMR_OFF_CNT, {24'h0, v});
      cyc(50);
      rd(`TMR_OFF_CNT, q);
      chk("stopped count", q, {24'h0, v});
      // Counter write blocks the match at the next tick
      v = 8'($urandom_range(16, 224));
      wr(`TMR_OFF_CMP, {24'h0, v});
      wr(`TMR_OFF_CNT, {24'h0, v});
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_DIV1));
      cyc(2);
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
      rd(`TMR_OFF_FLAG, q);
      chk("blocked match", q, 32'h0);
      // Clear on match, compare flag, mask and acknowledge
      v = 8'($urandom_range(32, 127));
      wr(`TMR_OFF_CMP, {24'h0, v});
      wr(`TMR_OFF_CNT, {24'h0, v - 8'h05});
      wr(`TMR_OFF_CTRL, ctl(1'b1, 2'd3, TMR_CTC, CS_STOP));
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd2, TMR_CTC, CS_DIV1));
      cyc(20);
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_CTC, CS_STOP));
      rd(`TMR_OFF_FLAG, q);
      chk("compare flag", q, 32'h2);
      chk("match clears output", {31'h0, compare_output}, 32'h0);
      rd(`TMR_OFF_CNT, q);
      chk("reload below compare", {31'h0, q < v}, 32'h1);
      wr(`TMR_OFF_MASK, 32'h2);
      cyc(1);
      chk("cmp request", {31'h0, irq_cmp}, 32'h1);
      chk("ovf masked", {31'h0, irq_ovf}, 32'h0);
      @(posedge pclk);
      cmp_irq_ack <= 1'b1;
      @(posedge pclk);
      cmp_irq_ack <= 1'b0;
      cyc(2);
      chk("cmp after ack", {31'h0, irq_cmp}, 32'h0);
      // Status flags for bottom, max and top
      wr(`TMR_OFF_CNT, {24'h0, v});
      rd(`TMR_OFF_STAT, q);
      chk("top at compare", q[2:1], 2'b10);
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
      wr(`TMR_OFF_CNT, {24'h0, `TMR_BOTTOM});
      rd(`TMR_OFF_STAT, q);
      chk("bottom", {31'h0, q[0]}, 32'h1);
      wr(`TMR_OFF_CNT, {24'h0, `TMR_MAX});
      rd(`TMR_OFF_STAT, q);
      chk("max and top", q[2:1], 2'b11);
      // Overflow, cleared by writing one, then by acknowledge
      wr(`TMR_OFF_MASK, 32'h1);
      for (int k = 0; k < 2; k++) begin
         wr(`TMR_OFF_CNT, 32'hFE);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_DIV1));
         cyc(10);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
         rd(`TMR_OFF_FLAG, q);
         chk("overflow flag", q, 32'h1);
         chk("ovf request", {31'h0, irq_ovf}, 32'h1);
         if (k == 0) begin
            wr(`TMR_OFF_FLAG, 32'h1);
         end else begin
            @(posedge pclk);
            ovf_irq_ack <= 1'b1;
            @(posedge pclk);
            ovf_irq_ack <= 1'b0;
         end
         rd(`TMR_OFF_FLAG, q);
         chk("overflow cleared", q, 32'h0);
      end
      // Phase-correct turns round at max
      wr(`TMR_OFF_CNT, 32'hFC);
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_PC_PWM, CS_DIV1));
      cyc(8);
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_PC_PWM, CS_STOP));
      rd(`TMR_OFF_STAT, q);
      chk("counting down", {31'h0, q[3]}, 32'h1);
      // Write beats a running count
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_DIV1));
      v = 8'($urandom_range(0, 200));
      wr(`TMR_OFF_CNT, {24'h0, v});
      rd(`TMR_OFF_CNT, q);
      chk("write priority", in_range(q, int'(v)), 32'h1);
      // Every prescaler tap
      wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
      foreach (TAPS[i]) begin
         wr(`TMR_OFF_CNT, 32'h0);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL,
                                tmr_clksel_t'(i + 1)));
         cyc(10 << TAPS[i]);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
         rd(`TMR_OFF_CNT, q);
         chk("prescaled count", in_range(q, 10), 32'h1);
      end
      // External input on both edges
      for (int s = 0; s < 2; s++) begin
         n = $urandom_range(1, 12);
         wr(`TMR_OFF_CNT, 32'h0);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL,
                                s ? CS_EXT_FALL : CS_EXT_RISE));
         repeat (n) begin
            @(posedge pclk);
            ext_count_input <= 1'b1;
            cyc(4);
            ext_count_input <= 1'b0;
            cyc(3);
         end
         cyc(8);
         wr(`TMR_OFF_CTRL, ctl(1'b0, 2'd0, TMR_NORMAL, CS_STOP));
         rd(`TMR_OFF_CNT, q);
         chk("external count", q, 32'(n));
      end
      give_verdict();
   end
endmodule : timer8_single_compare_pwm_bench
`default_nettype wire
